// *** inc/meter_pkg.sv ***
// Shared constants and types of the rms and active power datapath
package meter_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_MODE_TWO = 8'h0c;
  localparam logic [7:0] IDX_NO_LOAD = 8'h0e;
  localparam logic [7:0] IDX_ACCUM = 8'h0f;
  localparam logic [7:0] IDX_GAIN = 8'h1d;
  localparam logic [7:0] IDX_POFFSET = 8'h20;
  localparam logic [7:0] IDX_RMS_OFFSET = 8'h23;
  localparam logic [7:0] IDX_RMS_LOW = 8'hd1;
  localparam logic [7:0] IDX_RMS_MID = 8'hd2;
  localparam logic [7:0] IDX_RMS_HIGH = 8'hd3;
  localparam logic [7:0] IDX_IRQ_EN = 8'hd9;
  localparam logic [7:0] IDX_IRQ_ST = 8'hdc;

  // ==========================================================
  // Field positions
  localparam int ZX_GATE_BIT = 2;
  localparam int SIGN_DIR_BIT = 4;
  localparam int NO_LOAD_BIT = 0;
  localparam int SIGN_CHG_BIT = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_GAIN = 12'h000;
  localparam logic [15:0] RST_POFFSET = 16'h0000;
  localparam logic [11:0] RST_RMS_OFFSET = 12'h000;

  // ==========================================================
  // Timing and datapath constants
  localparam logic [2:0] UPDATE_DIV = 3'h5;
  localparam int RMS_SHIFT = 12;
  localparam int PWR_SHIFT = 8;
  localparam int RMS_OFS_WEIGHT = 6;
  localparam int GAIN_SHIFT = 12;
  localparam int POFS_SHIFT = 8;
  // Mean absolute to rms, times 256: 1898124 at full scale
  localparam logic [16:0] RMS_SCALE = 17'h11c5c;
  localparam logic [23:0] RMS_MAX = 24'hffffff;
  // Filtered power at full scale, thresholds in parts per million
  localparam logic [31:0] PWR_FULL = 32'h000ccccd;
  localparam logic [31:0] NL_PPM_ONE = 32'h00000096;
  localparam logic [31:0] NL_PPM_TWO = 32'h0000004b;
  localparam logic [31:0] NL_PPM_THREE = 32'h00000025;
  localparam logic [31:0] PPM_DIV = 32'h000f4240;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [15:0] volt;
    logic [23:0] curr;
  } sample_t;

  typedef struct packed {
    logic [7:0] index;
    logic aligned;
    logic write;
    logic [31:0] wdata;
  } bus_req_t;

endpackage : meter_pkg

// *** rtl/volt_rms_result_active_power_calc.sv ***
// Voltage rms and active power datapath with APB registers
// Notes on behaviour
// - Rms result in three byte registers
// - Rms estimated by mean absolute value
// - Rms refreshed every fifth clock
// - Gate bit limits rms update to crossings
// - Full-scale sine reads about 1898124
// - Add sixty-four times rms offset
// - Power is filtered voltage-current product
// - Power scaled by one plus gain/4096
// - Gain spans minus to plus fifty percent
// - Signed power offset added to power
// - Power offset counts 1/256 LSB
// - Sign change sets status bit three
// - Direction bit picks flagged transition
// - Enabled sign flag holds interrupt
// - No accumulation below no-load threshold
// - No-load sets status bit zero
// - Two-bit field selects threshold
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module volt_rms_result_active_power_calc
  import meter_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire sample_t samples,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic meter_irq,
  output logic [24:0] active_power,
  output logic energy_enable
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] abs_val(input logic [31:0] v);
    abs_val = v[31] ? (~v + 32'h00000001) : v;
  endfunction : abs_val

  function automatic logic [31:0] threshold(input logic [31:0] ppm);
    logic [63:0] prod;
    prod = PWR_FULL * ppm;
    threshold = 32'(prod / {32'h00000000, PPM_DIV});
  endfunction : threshold

  // ==========================================================
  // Registers
  logic [7:0] measure_mode_cfg_two;
  logic [7:0] no_load_threshold_cfg;
  logic [7:0] accumulation_cfg;
  logic [11:0] power_gain;
  logic [15:0] power_offset;
  logic [11:0] volt_rms_offset;
  logic [7:0] meter_irq_enable_one;
  logic [7:0] meter_irq_status_one;
  logic [23:0] volt_rms_result;

  bus_req_t req;
  logic bus_wr;
  logic [2:0] div_cnt;
  logic strobe;
  logic [27:0] rms_acc;
  logic volt_sign_prev;
  logic [31:0] pwr_acc;
  logic pwr_sign_prev;
  logic pwr_valid;

  // Bus request gathered in one carrier
  always_comb begin
    req.index = paddr[9:2];
    req.aligned = (paddr[1:0] == 2'b00);
    req.write = pwrite;
    req.wdata = pwdata;
  end

  // Write lands only on the edge that completes the access
  assign bus_wr = psel & penable & pready & req.write & req.aligned;

  // ==========================================================
  // Update strobe every five clocks
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      div_cnt <= 3'h0;
    end else if (div_cnt == UPDATE_DIV - 3'h1) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  assign strobe = (div_cnt == UPDATE_DIV - 3'h1);

  // ==========================================================
  // Voltage rms by mean absolute value
  logic [31:0] volt_ext;
  logic [15:0] volt_abs;
  logic [15:0] rms_avg;
  logic [32:0] rms_scaled;
  logic [26:0] rms_corr;
  logic [23:0] next_rms;
  logic volt_cross;

  always_comb begin
    volt_ext = {{16{samples.volt[15]}}, samples.volt};
    volt_abs = 16'(abs_val(volt_ext));
    rms_avg = rms_acc[27:12];
    rms_scaled = {16'h0000, rms_avg} * {16'h0000, RMS_SCALE};
    // Offset steps of 64 result LSBs, signed
    rms_corr = {2'b00, rms_scaled[32:8]}
      + 27'($signed({{15{volt_rms_offset[11]}}, volt_rms_offset}) <<< RMS_OFS_WEIGHT);
    // Clamp: a large negative offset must not wrap to full scale
    if (rms_corr[26]) begin
      next_rms = 24'h000000;
    end else if (rms_corr[25:24] != 2'b00) begin
      next_rms = RMS_MAX;
    end else begin
      next_rms = rms_corr[23:0];
    end
    volt_cross = (samples.volt[15] != volt_sign_prev);
  end

  // Averaging filter, one step per update strobe
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rms_acc <= 28'h0000000;
      volt_sign_prev <= 1'b0;
    end else if (strobe) begin
      rms_acc <= rms_acc + {12'h000, volt_abs} - (rms_acc >> RMS_SHIFT);
      volt_sign_prev <= samples.volt[15];
    end
  end

  // Result register, optionally gated to voltage zero crossings
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      volt_rms_result <= 24'h000000;
    end else if (strobe) begin
      if (!measure_mode_cfg_two[ZX_GATE_BIT] || volt_cross) begin
        volt_rms_result <= next_rms;
      end
    end
  end

  // ==========================================================
  // Active power: product, low-pass, gain, offset
  logic signed [39:0] product;
  logic signed [23:0] prod_top;
  logic signed [23:0] pwr_filt;
  logic signed [35:0] gain_prod;
  logic signed [24:0] pwr_gained;
  logic signed [32:0] pwr_fine;
  logic signed [24:0] next_power;

  always_comb begin
    product = $signed(samples.volt) * $signed(samples.curr);
    prod_top = product[39:16];
    pwr_filt = pwr_acc[31:8];
    gain_prod = pwr_filt * $signed(power_gain);
    pwr_gained = 25'(pwr_filt) + 25'(gain_prod >>> GAIN_SHIFT);
    // Offset is held in 1/256 of a power LSB
    pwr_fine = (33'(pwr_gained) <<< POFS_SHIFT) + 33'($signed(power_offset));
    next_power = 25'(pwr_fine >>> POFS_SHIFT);
  end

  // Filter is slow by design; ripple at twice line rate remains
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pwr_acc <= 32'h00000000;
    end else if (strobe) begin
      pwr_acc <= pwr_acc + {{8{prod_top[23]}}, prod_top} - 32'($signed(pwr_acc) >>> PWR_SHIFT);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      active_power <= 25'h0000000;
    end else if (strobe) begin
      active_power <= next_power;
    end
  end

  // ==========================================================
  // Sign change and no-load detection
  logic [31:0] nl_limit;
  logic below_limit;
  logic sign_event;
  logic nl_event;

  always_comb begin
    case (no_load_threshold_cfg[1:0])
      2'b01: nl_limit = threshold(NL_PPM_ONE);
      2'b10: nl_limit = threshold(NL_PPM_TWO);
      2'b11: nl_limit = threshold(NL_PPM_THREE);
      default: nl_limit = 32'h00000000;
    endcase
    below_limit = (no_load_threshold_cfg[1:0] != 2'b00)
      && (abs_val(32'($signed(active_power))) < nl_limit);
    // Clear direction bit: positive to negative; set: reverse
    if (accumulation_cfg[SIGN_DIR_BIT]) begin
      sign_event = pwr_valid && pwr_sign_prev && !active_power[24];
    end else begin
      sign_event = pwr_valid && !pwr_sign_prev && active_power[24];
    end
    nl_event = below_limit;
  end

  // Previous sign; first compare waits one strobe after reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pwr_sign_prev <= 1'b0;
      pwr_valid <= 1'b0;
    end else if (strobe) begin
      pwr_sign_prev <= active_power[24];
      pwr_valid <= 1'b1;
    end
  end

  // Energy path gate seen by the accumulator downstream
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      energy_enable <= 1'b0;
    end else begin
      energy_enable <= !below_limit;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      measure_mode_cfg_two <= RST_BYTE;
      no_load_threshold_cfg <= RST_BYTE;
      accumulation_cfg <= RST_BYTE;
      power_gain <= RST_GAIN;
      power_offset <= RST_POFFSET;
      volt_rms_offset <= RST_RMS_OFFSET;
      meter_irq_enable_one <= RST_BYTE;
    end else if (bus_wr) begin
      case (req.index)
        IDX_MODE_TWO: measure_mode_cfg_two <= req.wdata[7:0];
        IDX_NO_LOAD: no_load_threshold_cfg <= req.wdata[7:0];
        IDX_ACCUM: accumulation_cfg <= req.wdata[7:0];
        IDX_GAIN: power_gain <= req.wdata[11:0];
        IDX_POFFSET: power_offset <= req.wdata[15:0];
        IDX_RMS_OFFSET: volt_rms_offset <= req.wdata[11:0];
        IDX_IRQ_EN: meter_irq_enable_one <= req.wdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Sticky status, write one to clear; a new event beats the clear
  logic [7:0] st_set;
  logic [7:0] st_clr;

  always_comb begin
    st_set = 8'h00;
    st_set[SIGN_CHG_BIT] = sign_event && strobe;
    st_set[NO_LOAD_BIT] = nl_event;
    st_clr = (bus_wr && req.index == IDX_IRQ_ST) ? req.wdata[7:0] : 8'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meter_irq_status_one <= RST_BYTE;
    end else begin
      meter_irq_status_one <= (meter_irq_status_one & ~st_clr) | st_set;
    end
  end

  // Level interrupt from enabled flags
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meter_irq <= 1'b0;
    end else begin
      meter_irq <= |(meter_irq_status_one & meter_irq_enable_one);
    end
  end

  // ==========================================================
  // APB answer: one wait state, then ready for one cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // Read data and error captured with ready
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= !req.aligned;
      prdata <= 32'h00000000;
      if (req.aligned) begin
        case (req.index)
          IDX_MODE_TWO: prdata <= {24'h000000, measure_mode_cfg_two};
          IDX_NO_LOAD: prdata <= {24'h000000, no_load_threshold_cfg};
          IDX_ACCUM: prdata <= {24'h000000, accumulation_cfg};
          IDX_GAIN: prdata <= {20'h00000, power_gain};
          IDX_POFFSET: prdata <= {16'h0000, power_offset};
          IDX_RMS_OFFSET: prdata <= {20'h00000, volt_rms_offset};
          IDX_RMS_LOW: prdata <= {24'h000000, volt_rms_result[7:0]};
          IDX_RMS_MID: prdata <= {24'h000000, volt_rms_result[15:8]};
          IDX_RMS_HIGH: prdata <= {24'h000000, volt_rms_result[23:16]};
          IDX_IRQ_EN: prdata <= {24'h000000, meter_irq_enable_one};
          IDX_IRQ_ST: prdata <= {24'h000000, meter_irq_status_one};
          default: pslverr <= 1'b1;
        endcase
      end
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

endmodule : volt_rms_result_active_power_calc

`default_nettype wire

// *** sim/sample_source.sv ***
// Stand-in for the decimated voltage and current sample paths
`timescale 1ns/1ps
`default_nettype none
module sample_source
  import meter_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [15:0] volt_level,
  input wire logic [23:0] curr_level,
  output var sample_t samples
);
  // Registered like a decimator output, so samples never move mid-cycle
  always_ff @(posedge clk_sys) begin
    samples.volt <= volt_level;
    samples.curr <= curr_level;
  end
endmodule : sample_source
`default_nettype wire

// *** sim/volt_rms_result_active_power_calc_tb.sv ***
// Self-checking bench for the rms and active power block
`timescale 1ns/1ps
`default_nettype none
module volt_rms_result_active_power_calc_tb
  import meter_pkg::*;
;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, meter_irq, energy_enable, rerr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdata, first;
  logic [24:0] active_power;
  logic [15:0] volt_level;
  logic [23:0] curr_level;
  sample_t samples;
  int num_errors, checks, cycles;
  logic [7:0] idx_tab [0:10] = '{IDX_IRQ_ST, IDX_IRQ_EN, IDX_MODE_TWO, IDX_NO_LOAD, IDX_ACCUM, IDX_GAIN,
    IDX_POFFSET, IDX_RMS_OFFSET, IDX_RMS_LOW, IDX_RMS_MID, IDX_RMS_HIGH};
  logic [31:0] mask_tab [0:10] = '{32'h0, 32'hff, 32'hff, 32'hff, 32'hff, 32'hfff, 32'hffff, 32'hfff,
    32'h0, 32'h0, 32'h0};

  sample_source i_src (.clk_sys(clk_sys), .volt_level(volt_level), .curr_level(curr_level), .samples(samples));
  volt_rms_result_active_power_calc i_dut (.clk_sys(clk_sys), .nrst(nrst), .samples(samples), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meter_irq(meter_irq), .active_power(active_power), .energy_enable(energy_enable));

  // ==========================================================
  // Clock, timeout and reporting
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Longest path is about 22000 cycles, so this only trips on a hang
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // Bus tasks: request held until pready is sampled high
  task xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, {idx, 2'b00}, d);
  endtask : wr
  task rd(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, {idx, 2'b00}, 32'h0);
    check(rdata, exp);
  endtask : rd
  task waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : waitc
  // ==========================================================
  // Test sequence
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h0;
    pwdata = 32'h0;
    volt_level = 16'h0;
    curr_level = 24'h0;
    waitc(16);
    nrst <= 1'b1;
    // Reset values, then write-all-ones shows each configuration register's width; status and rms bytes read back zero
    foreach (idx_tab[i]) begin
      rd(idx_tab[i], 32'h0);
      wr(idx_tab[i], 32'hffffffff);
      rd(idx_tab[i], mask_tab[i]);
      wr(idx_tab[i], 32'h0);
    end
    xfer(1'b0, {8'h40, 2'b00}, 32'h0);
    check({31'h0, rerr}, 32'h1);
    check(rdata, 32'h0);
    xfer(1'b1, 10'h031, 32'h1);
    check({31'h0, rerr}, 32'h1);
    $display("registers done");
    // Offset-made loads of 40 and -40 sit between the two lower thresholds
    wr(IDX_POFFSET, 32'h2800);
    wr(IDX_NO_LOAD, 32'h3);
    waitc(12);
    check({31'h0, energy_enable}, 32'h1);
    wr(IDX_NO_LOAD, 32'h2);
    waitc(4);
    check({31'h0, energy_enable}, 32'h0);
    wr(IDX_POFFSET, 32'hd800);
    waitc(12);
    check({7'h0, active_power}, 32'h01ffffd8);
    check({31'h0, energy_enable}, 32'h0);
    wr(IDX_POFFSET, 32'h0);
    wr(IDX_NO_LOAD, 32'h0);
    waitc(12);
    // Zero power is below every threshold except the disabled code
    wr(IDX_IRQ_ST, 32'hff);
    wr(IDX_IRQ_EN, 32'h01);
    for (int m = 3; m >= 0; m--) begin
      wr(IDX_NO_LOAD, m);
      waitc(4);
      check({31'h0, energy_enable}, {31'h0, m == 0});
    end
    rd(IDX_IRQ_ST, 32'h01);
    check({31'h0, meter_irq}, 32'h1);
    wr(IDX_IRQ_ST, 32'h01);
    waitc(3);
    rd(IDX_IRQ_ST, 32'h0);
    check({31'h0, meter_irq}, 32'h0);
    $display("no-load done");
    // Offset in steps of 64, clamped at zero when negative
    wr(IDX_RMS_OFFSET, 32'h010);
    waitc(12);
    rd(IDX_RMS_MID, 32'h04);
    wr(IDX_RMS_OFFSET, 32'hff0);
    waitc(12);
    rd(IDX_RMS_MID, 32'h0);
    wr(IDX_RMS_OFFSET, 32'h0);
    $display("rms offset done");
    // Product of exactly 4096 settles fully, so gain and offset give exact values
    volt_level <= 16'h1000;
    curr_level <= 24'h010000;
    waitc(12500);
    check({7'h0, active_power}, 32'h1000);
    wr(IDX_GAIN, 32'h7ff);
    waitc(12);
    check({7'h0, active_power}, 32'h17ff);
    wr(IDX_GAIN, 32'h800);
    waitc(12);
    check({7'h0, active_power}, 32'h800);
    wr(IDX_GAIN, 32'h001);
    waitc(12);
    check({7'h0, active_power}, 32'h1001);
    wr(IDX_GAIN, 32'h0);
    wr(IDX_POFFSET, 32'h100);
    waitc(12);
    check({7'h0, active_power}, 32'h1001);
    wr(IDX_POFFSET, 32'h0);
    $display("power gain done");
    // Positive load, rms settling, then gated rms freezes
    volt_level <= 16'h4000;
    curr_level <= 24'h400000;
    wr(IDX_IRQ_EN, 32'h08);
    waitc(2000);
    check({31'h0, energy_enable}, 32'h1);
    xfer(1'b0, {IDX_RMS_MID, 2'b00}, 32'h0);
    first = rdata;
    waitc(50);
    xfer(1'b0, {IDX_RMS_MID, 2'b00}, 32'h0);
    check({31'h0, rdata !== first}, 32'h1);
    wr(IDX_MODE_TWO, 32'h04);
    waitc(10);
    xfer(1'b0, {IDX_RMS_MID, 2'b00}, 32'h0);
    first = rdata;
    waitc(100);
    rd(IDX_RMS_MID, first);
    wr(IDX_MODE_TWO, 32'h0);
    // Reversing current flips the power sign
    curr_level <= 24'hc00000;
    waitc(2000);
    check({31'h0, active_power[24]}, 32'h1);
    rd(IDX_IRQ_ST, 32'h08);
    check({31'h0, meter_irq}, 32'h1);
    wr(IDX_IRQ_ST, 32'h08);
    waitc(3);
    check({31'h0, meter_irq}, 32'h0);
    wr(IDX_ACCUM, 32'h10);
    curr_level <= 24'h400000;
    waitc(2000);
    rd(IDX_IRQ_ST, 32'h08);
    wr(IDX_IRQ_ST, 32'h08);
    curr_level <= 24'hc00000;
    waitc(2000);
    rd(IDX_IRQ_ST, 32'h0);
    $display("power sign done");
    tally_and_finish();
  end
endmodule : volt_rms_result_active_power_calc_tb
`default_nettype wire

// *** sim/volt_rms_result_calc_asserts.sv ***
// Port-level assertions for the rms and active power block
`timescale 1ns/1ps
`default_nettype none
module volt_rms_result_calc_asserts
  import meter_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire sample_t samples,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic meter_irq,
  input wire logic [24:0] active_power,
  input wire logic energy_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Helper logic
  logic wr_done;
  logic big_power;
  logic [7:0] en_copy;
  logic [1:0] nl_copy;
  assign wr_done = psel && penable && pready && pwrite && paddr[1:0] == 2'b00;
  // Margin well above the largest threshold, so no borderline cases
  assign big_power = $signed(active_power) > 25'sd400 || $signed(active_power) < -25'sd400;
  // Shadows of enable and threshold, landing on the same edge as the write
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      en_copy <= 8'h00;
      nl_copy <= 2'h0;
    end else begin
      if (wr_done && paddr[9:2] == IDX_IRQ_EN) en_copy <= pwdata[7:0];
      if (wr_done && paddr[9:2] == IDX_NO_LOAD) nl_copy <= pwdata[1:0];
    end
  end
  // ==========================================================
  // Assertions
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  ready_wait_a: assert property (s_access |=> s_answer) else $error("ready not one wait state");
  // Error flag may linger for the one cycle in which select has just dropped
  err_idle_a: assert property (!psel && !$past(psel) |-> !pready && !pslverr) else $error("answer without select");
  rms_upper_a: assert property (pready && !pwrite && paddr[9:2] >= IDX_RMS_LOW && paddr[9:2] <= IDX_RMS_HIGH
    |-> prdata[31:8] == 24'h0) else $error("rms byte read has upper bits");
  power_cadence_a: assert property ($changed(active_power) |=> $stable(active_power)[*4])
    else $error("power changed inside five clocks");
  irq_sticky_a: assert property (meter_irq && !wr_done && !$past(wr_done) |=> meter_irq)
    else $error("interrupt dropped without a write");
  irq_masked_a: assert property ((en_copy == 8'h00)[*3] |-> !meter_irq)
    else $error("interrupt with all enables off");
  noload_off_a: assert property ((nl_copy == 2'h0)[*4] |-> energy_enable)
    else $error("no-load gate active while disabled");
  load_enables_a: assert property (big_power && $past(big_power) |-> energy_enable)
    else $error("energy blocked at large power");
endmodule : volt_rms_result_calc_asserts

bind volt_rms_result_active_power_calc volt_rms_result_calc_asserts i_chk (.clk_sys(clk_sys), .nrst(nrst), .samples(samples),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .meter_irq(meter_irq), .active_power(active_power),
  .energy_enable(energy_enable));
`default_nettype wire
